// [src/swd_pkg.sv]
`default_nettype none
package swd_pkg;
    // Register byte offsets inside the 16 KiB window
    localparam int          ADDR_W    = 14;
    localparam logic [13:0] OFS_CTRL  = 14'h0000;
    localparam logic [13:0] OFS_FLAG  = 14'h0004;
    localparam logic [13:0] OFS_TO    = 14'h0008;
    localparam logic [13:0] OFS_WN    = 14'h000c;
    localparam logic [13:0] OFS_SR    = 14'h0010;
    localparam logic [13:0] OFS_CO    = 14'h0014;
    localparam logic [13:0] OFS_KEY   = 14'h0018;

    // Control word fields; master n permit sits at bit 31-n
    localparam int          CTRL_MAP_MSB = 31;
    localparam int          CTRL_KEY     = 9;
    localparam int          CTRL_BADRST  = 8;
    localparam int          CTRL_WIN     = 7;
    localparam int          CTRL_IRQ1ST  = 6;
    localparam int          CTRL_HARD    = 5;
    localparam int          CTRL_SOFT    = 4;
    localparam int          CTRL_STOPH   = 2;
    localparam int          CTRL_DBGH    = 1;
    localparam int          CTRL_WEN     = 0;
    localparam logic [31:0] CTRL_RST     = 32'hff00_0113;
    localparam logic [31:0] CTRL_WMASK   = 32'hff00_03f7;
    localparam logic [31:0] CTRL_LOCKS   = 32'h0000_0030;
    localparam int          FLAG_TOBIT   = 0;

    // Reset values of the period, window and key
    localparam logic [31:0] TO_RST = 32'h0000_0fff;
    localparam logic [31:0] WN_RST = 32'h0000_0000;
    localparam logic [15:0] KEY_RST = 16'h0000;
    localparam logic [31:0] TO_MIN = 32'h0000_0100;

    // Service and unlock codes
    localparam logic [15:0] SVC_CODE_1    = 16'ha602;
    localparam logic [15:0] SVC_CODE_2    = 16'hb480;
    localparam logic [15:0] UNLOCK_CODE_1 = 16'hc520;
    localparam logic [15:0] UNLOCK_CODE_2 = 16'hd928;
    localparam logic [15:0] KEY_MUL       = 16'h0011;
    localparam logic [15:0] KEY_ADD       = 16'h0003;

    // Bus encodings
    localparam logic [2:0]  HSIZE_WORD = 3'h2;
    localparam int          HTRANS_ACT = 1;

    // Counter clock divider: counter ticks once every TICK_DIV system cycles
    localparam logic [3:0]  TICK_DIV = 4'h1;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [2:0]  hmaster;
        logic [31:0] hwdata;
    } swd_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } swd_ahb_rsp_t;

    typedef enum logic [1:0] {
        SWD_BUS_IDLE,
        SWD_BUS_ACCESS,
        SWD_BUS_ERR2
    } swd_bus_state_t;
endpackage
`default_nettype wire

// [src/swd_top.sv]
`default_nettype none
// Summary of operation
// - Per-master permit bit gates bus access
// - Fixed pair a602 then b480 reloads counter
// - Keyed mode accepts two pseudorandom keys only
// - Next key is 17 times key plus 3
// - Key register holds previous or initial key
// - Invalid access without reset option gives error
// - Invalid access with option and enabled resets
// - Window mode services only below window start
// - Timeout resets, or interrupt first then reset
// - Hard lock clears only by reset, blocks writes
// - Pair c520 then d928 clears soft lock
// - Period register read-only while any lock set
// - Stop halt bit freezes counter in stop
// - Debug halt bit freezes counter in debug
// - Load max of period and 0x100 on service
// - Timeout flag set on first timeout, W1C
// - Window start clears to zero on reset
// - Readback shows counter disabled, zero enabled
// - Readback lag bounded by a few cycles
// - Unlock pair recognised anytime, even disabled
// - Keyed mode stores each valid key written
// - Service outside open window is invalid while enabled
module swd_top
    import swd_pkg::*;
(
    // Clock and reset
    input  wire  logic                  i_ref_clk,
    input  wire  logic                  i_rst_n,
    // Register bus
    input  wire  swd_pkg::swd_ahb_req_t i_ahb_req,
    output var   swd_pkg::swd_ahb_rsp_t o_ahb_rsp,
    // Device modes
    input  wire  logic                  i_stop_mode,
    input  wire  logic                  i_debug_mode,
    // Events
    output logic                        o_irq,
    output logic                        o_sys_reset_req
);
    import swd_pkg::*;

    function automatic logic [15:0] next_key(input logic [15:0] k);
        next_key = 16'(k * KEY_MUL + KEY_ADD);
    endfunction

    function automatic logic [31:0] load_value(input logic [31:0] t);
        load_value = (t < TO_MIN) ? TO_MIN : t;
    endfunction

    swd_bus_state_t bus_st_q;
    swd_ahb_rsp_t   rsp_q;
    logic           a_wr_q;
    logic [13:0]    a_addr_q;
    logic           a_bad_q;
    logic [31:0]    ctrl_q;
    logic           flag_q;
    logic [31:0]    to_q;
    logic [31:0]    wn_q;
    logic [15:0]    key_q;
    logic [31:0]    cnt_q;
    logic [31:0]    co_q;
    logic           svc_half_q;
    logic           unlock_armed_q;
    logic           to_pend_q;
    logic           wen_prev_q;
    logic           rst_req_q;
    logic [3:0]     div_q;

    logic        access;
    logic        addr_take;
    logic        addr_bad;
    logic [15:0] svc_code;
    logic        locked;
    logic        sr_wr;
    logic        unlock_code;
    logic [15:0] exp_code;
    logic        win_open;
    logic        code_ok;
    logic        svc_bad;
    logic        lock_bad;
    logic        ro_bad;
    logic        invalid;
    logic        write_ok;
    logic        sr_ok;
    logic        svc_step;
    logic        svc_done;
    logic        unlock_done;
    logic        bus_err;
    logic        wen;
    logic        tick;
    logic        running;
    logic        load;
    logic        timeout;
    logic [31:0] rdata;

    assign wen       = ctrl_q[CTRL_WEN];
    assign access    = (bus_st_q == SWD_BUS_ACCESS);
    assign addr_take = i_ahb_req.hsel & i_ahb_req.htrans[HTRANS_ACT] & i_ahb_req.hready;

    // Size, alignment, reserved space and master permission checked at address phase
    always_comb begin
        addr_bad = (i_ahb_req.hsize != HSIZE_WORD) || (i_ahb_req.haddr[1:0] != 2'h0)
                 || (i_ahb_req.haddr[13:0] > OFS_KEY)
                 || !ctrl_q[CTRL_MAP_MSB - int'(i_ahb_req.hmaster)];
    end

    // Data phase decode; service code is only known once hwdata stands
    assign svc_code    = i_ahb_req.hwdata[15:0];
    assign locked      = ctrl_q[CTRL_HARD] | ctrl_q[CTRL_SOFT];
    assign sr_wr       = access & a_wr_q & (a_addr_q == OFS_SR);
    assign unlock_code = (svc_code == UNLOCK_CODE_1) || (svc_code == UNLOCK_CODE_2);
    always_comb begin
        if (ctrl_q[CTRL_KEY]) begin
            exp_code = next_key(key_q);
        end else begin
            exp_code = svc_half_q ? SVC_CODE_2 : SVC_CODE_1;
        end
    end
    assign win_open = !ctrl_q[CTRL_WIN] || (cnt_q < wn_q);
    assign code_ok  = (svc_code == exp_code) && win_open;
    assign svc_bad  = sr_wr & !unlock_code & wen & !code_ok;
    assign lock_bad = access & a_wr_q & locked
                    & ((a_addr_q == OFS_CTRL) || (a_addr_q == OFS_TO)
                    || (a_addr_q == OFS_WN) || (a_addr_q == OFS_KEY));
    assign ro_bad   = access & a_wr_q & (a_addr_q == OFS_CO);
    assign invalid  = access & (a_bad_q | lock_bad | ro_bad | svc_bad);
    assign write_ok = access & a_wr_q & !invalid;
    assign sr_ok    = write_ok & (a_addr_q == OFS_SR);
    assign svc_step = sr_ok & !unlock_code & code_ok;
    assign svc_done = svc_step & svc_half_q;
    assign unlock_done = sr_ok & unlock_armed_q & (svc_code == UNLOCK_CODE_2);
    assign bus_err  = invalid & !(ctrl_q[CTRL_BADRST] & wen);

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (a_addr_q)
            OFS_CTRL: rdata = ctrl_q;
            OFS_FLAG: rdata = {31'h0000_0000, flag_q};
            OFS_TO:   rdata = to_q;
            OFS_WN:   rdata = wn_q;
            OFS_CO:   rdata = co_q;
            OFS_KEY:  rdata = {16'h0000, key_q};
            default:  rdata = 32'h0000_0000;
        endcase
    end

    // Bus slave: one wait state on every transfer, two-cycle ERROR when refused
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            bus_st_q <= SWD_BUS_IDLE;
            rsp_q    <= '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0};
            a_wr_q   <= 1'b0;
            a_addr_q <= 14'h0000;
            a_bad_q  <= 1'b0;
        end else begin
            unique case (bus_st_q)
                SWD_BUS_IDLE: begin
                    rsp_q.hresp     <= 1'b0;
                    rsp_q.hreadyout <= 1'b1;
                    if (addr_take) begin
                        a_wr_q          <= i_ahb_req.hwrite;
                        a_addr_q        <= i_ahb_req.haddr[13:0];
                        a_bad_q         <= addr_bad;
                        rsp_q.hreadyout <= 1'b0;
                        bus_st_q        <= SWD_BUS_ACCESS;
                    end
                end
                SWD_BUS_ACCESS: begin
                    rsp_q.hrdata <= (a_wr_q || invalid) ? 32'h0000_0000 : rdata;
                    if (bus_err) begin
                        rsp_q.hresp <= 1'b1;
                        bus_st_q    <= SWD_BUS_ERR2;
                    end else begin
                        rsp_q.hreadyout <= 1'b1;
                        bus_st_q        <= SWD_BUS_IDLE;
                    end
                end
                SWD_BUS_ERR2: begin
                    rsp_q.hreadyout <= 1'b1;
                    bus_st_q        <= SWD_BUS_IDLE;
                end
            endcase
        end
    end

    // Control word; writes can set lock bits but never clear them; reset loads the soft lock set
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ctrl_q <= CTRL_RST;
        end else begin
            if (write_ok && a_addr_q == OFS_CTRL) begin
                ctrl_q <= (i_ahb_req.hwdata & CTRL_WMASK) | (ctrl_q & CTRL_LOCKS);
            end
            if (unlock_done) begin
                ctrl_q[CTRL_SOFT] <= 1'b0;
            end
        end
    end

    // Period and window registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            to_q <= TO_RST;
            wn_q <= WN_RST;
        end else begin
            if (write_ok && a_addr_q == OFS_TO) begin
                to_q <= i_ahb_req.hwdata;
            end
            if (write_ok && a_addr_q == OFS_WN) begin
                wn_q <= i_ahb_req.hwdata;
            end
        end
    end

    // Unlock tracker sees every accepted service-target write, independent of service state
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            unlock_armed_q <= 1'b0;
        end else if (sr_ok) begin
            unlock_armed_q <= (svc_code == UNLOCK_CODE_1);
        end
    end

    // Service sequence and key state; unlock codes pass through untouched
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            svc_half_q <= 1'b0;
            key_q      <= KEY_RST;
        end else begin
            if (write_ok && a_addr_q == OFS_KEY) begin
                key_q <= i_ahb_req.hwdata[15:0];
            end
            if (svc_step) begin
                svc_half_q <= !svc_half_q;
                if (ctrl_q[CTRL_KEY]) begin
                    key_q <= svc_code;
                end
            end else if (sr_wr && !unlock_code) begin
                svc_half_q <= 1'b0;
            end
        end
    end

    // Counter clock enable from divider
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            div_q <= 4'h0;
        end else if (div_q >= TICK_DIV - 4'h1) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    assign tick = (div_q >= TICK_DIV - 4'h1);

    assign running = wen & !(ctrl_q[CTRL_STOPH] & i_stop_mode)
                   & !(ctrl_q[CTRL_DBGH] & i_debug_mode);
    assign load    = (wen & !wen_prev_q) | svc_done;
    assign timeout = running & tick & (cnt_q == 32'h0000_0000) & !load;

    // Down counter
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_q      <= 32'h0000_0000;
            wen_prev_q <= 1'b0;
        end else begin
            wen_prev_q <= wen;
            if (load) begin
                cnt_q <= load_value(to_q);
            end else if (timeout) begin
                if (ctrl_q[CTRL_IRQ1ST] && !to_pend_q) begin
                    cnt_q <= load_value(to_q);
                end
            end else if (running && tick) begin
                cnt_q <= cnt_q - 32'h0000_0001;
            end
        end
    end

    // Escalation: first timeout pending until serviced
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            to_pend_q <= 1'b0;
        end else if (timeout && ctrl_q[CTRL_IRQ1ST]) begin
            to_pend_q <= 1'b1;
        end else if (svc_done) begin
            to_pend_q <= 1'b0;
        end
    end

    // Timeout flag; a first timeout wins over a same-cycle clear
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            flag_q <= 1'b0;
        end else if (timeout && ctrl_q[CTRL_IRQ1ST] && !to_pend_q) begin
            flag_q <= 1'b1;
        end else if (write_ok && a_addr_q == OFS_FLAG && i_ahb_req.hwdata[FLAG_TOBIT]) begin
            flag_q <= 1'b0;
        end
    end

    // Reset request stays up; the system reset it causes clears it
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            rst_req_q <= 1'b0;
        end else if (timeout && (!ctrl_q[CTRL_IRQ1ST] || to_pend_q)) begin
            rst_req_q <= 1'b1;
        end else if (invalid && ctrl_q[CTRL_BADRST] && wen) begin
            rst_req_q <= 1'b1;
        end
    end

    // Readback copy, one cycle behind the counter
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            co_q <= 32'h0000_0000;
        end else begin
            co_q <= wen ? 32'h0000_0000 : cnt_q;
        end
    end

    assign o_ahb_rsp       = rsp_q;
    assign o_irq           = flag_q;
    assign o_sys_reset_req = rst_req_q;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_err_resp;
        (!rsp_q.hreadyout && rsp_q.hresp) ##1 (rsp_q.hreadyout && rsp_q.hresp);
    endsequence

    sequence s_first_timeout;
        timeout && ctrl_q[CTRL_IRQ1ST] && !to_pend_q;
    endsequence

    a_bus_error_pair: assert property (bus_err |=> s_err_resp)
        else $error("invalid access did not give two-cycle error");

    a_reset_on_bad: assert property (invalid && ctrl_q[CTRL_BADRST] && wen |=> rst_req_q && !rsp_q.hresp)
        else $error("invalid access with reset option did not request reset");

    a_first_timeout_irq: assert property (s_first_timeout |=> flag_q && o_irq && !rst_req_q
                                          && cnt_q == load_value($past(to_q)))
        else $error("first timeout did not raise flag and reload");

    a_timeout_reset: assert property (timeout && !ctrl_q[CTRL_IRQ1ST] |=> rst_req_q)
        else $error("timeout without interrupt option did not reset");

    a_hard_lock_hold: assert property (ctrl_q[CTRL_HARD] |=> ctrl_q[CTRL_HARD])
        else $error("hard lock cleared without reset");

    a_locked_period: assert property (access && a_wr_q && a_addr_q == OFS_TO && locked
                                      |=> $stable(to_q) ##1 rsp_q.hresp || rst_req_q)
        else $error("period register changed while locked");

    a_unlock_clears: assert property (unlock_done |=> !ctrl_q[CTRL_SOFT])
        else $error("unlock pair did not clear soft lock");

    a_service_reload: assert property (svc_done |=> cnt_q == load_value($past(to_q))
                                       && cnt_q >= TO_MIN)
        else $error("service did not load the period");

    a_keyed_update: assert property (svc_step && ctrl_q[CTRL_KEY]
                                     |=> key_q == $past(svc_code) && key_q == next_key($past(key_q)))
        else $error("key state not advanced by valid key");

    a_flag_clear: assert property (write_ok && a_addr_q == OFS_FLAG && i_ahb_req.hwdata[FLAG_TOBIT]
                                   && !timeout |=> !flag_q)
        else $error("flag not cleared by writing one");

    a_readback_zero: assert property (wen ##1 wen |-> co_q == 32'h0000_0000)
        else $error("readback not zero while enabled");

    a_debug_freeze: assert property (i_debug_mode && ctrl_q[CTRL_DBGH] && !load
                                     |=> cnt_q == $past(cnt_q))
        else $error("counter moved while frozen in debug");

    a_window_closed: assert property (sr_wr && ctrl_q[CTRL_WIN] && wen && !unlock_code
                                      && cnt_q >= wn_q |-> invalid && !svc_done)
        else $error("service accepted outside window");
endmodule
`default_nettype wire

// [test/tb_software_watchdog_regs.sv]
`default_nettype none
module tb_software_watchdog_regs
    import swd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         i_ref_clk;
    logic         i_rst_n;
    swd_ahb_req_t m_q;
    swd_ahb_req_t req;
    swd_ahb_rsp_t rsp;
    logic         stop;
    logic         dbg;
    logic         irq;
    logic         srr;
    logic [2:0]   mst;
    logic [31:0]  rd_v;
    logic         err_v;
    int           n_errors;
    int           n_tests;
    int           cyc;

    swd_top dut (
        .i_ref_clk       (i_ref_clk),
        .i_rst_n         (i_rst_n),
        .i_ahb_req       (req),
        .o_ahb_rsp       (rsp),
        .i_stop_mode     (stop),
        .i_debug_mode    (dbg),
        .o_irq           (irq),
        .o_sys_reset_req (srr)
    );

    always #4 i_ref_clk = ~i_ref_clk;

    // Single slave, so its ready is the bus ready
    always_comb begin
        req        = m_q;
        req.hready = rsp.hreadyout;
    end

    always @(posedge i_ref_clk) begin
        cyc = cyc + 1;
        if (cyc > 40000) begin
            n_errors = n_errors + 1;
            results();
        end
    end

    task automatic results();
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // Address phase held until ready, then data phase held until ready
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        m_q.hsel    <= 1'b1;
        m_q.haddr   <= {18'h00000, a};
        m_q.htrans  <= 2'h2;
        m_q.hwrite  <= w;
        m_q.hsize   <= HSIZE_WORD;
        m_q.hmaster <= mst;
        do @(posedge i_ref_clk); while (rsp.hreadyout !== 1'b1);
        m_q.htrans  <= 2'h0;
        m_q.hsel    <= 1'b0;
        m_q.hwdata  <= d;
        do @(posedge i_ref_clk); while (rsp.hreadyout !== 1'b1);
        rd_v  = rsp.hrdata;
        err_v = rsp.hresp;
    endtask

    task automatic rchk(input string nm, input logic [13:0] a, input logic [31:0] exp, input logic e);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, rd_v, exp);
        chk(nm, {31'h0, err_v}, {31'h0, e});
    endtask

    task automatic wchk(input string nm, input logic [13:0] a, input logic [31:0] d, input logic e);
        bus(1'b1, a, d);
        chk(nm, {31'h0, err_v}, {31'h0, e});
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    // Polls the event output; the caller judges what was reached
    task automatic wait_sig(input bit use_irq, input int lim);
        repeat (lim) begin
            @(posedge i_ref_clk);
            if ((use_irq ? irq : srr) === 1'b1) break;
        end
    endtask

    function automatic logic [15:0] nk(input logic [15:0] k);
        return k * 16'h0011 + 16'h0003;
    endfunction

    task automatic rst();
        i_rst_n <= 1'b0;
        wt(20);
        i_rst_n <= 1'b1;
    endtask

    task automatic svc(input logic [15:0] c1, input logic [15:0] c2);
        bus(1'b1, OFS_SR, {16'h0000, c1});
        bus(1'b1, OFS_SR, {16'h0000, c2});
    endtask

    // Disable then enable so the period load happens at a known write
    task automatic cfg(input logic [31:0] to, input logic [31:0] wn, input logic [31:0] ctrl);
        rst();
        svc(UNLOCK_CODE_1, UNLOCK_CODE_2);
        bus(1'b1, OFS_TO, to);
        bus(1'b1, OFS_WN, wn);
        bus(1'b1, OFS_CTRL, ctrl & 32'hffff_fffe);
        bus(1'b1, OFS_CTRL, ctrl);
    endtask

    task automatic t_reset();
        rst();
        rchk("ctrl", OFS_CTRL, CTRL_RST, 1'b0);
        rchk("period", OFS_TO, TO_RST, 1'b0);
        rchk("window", OFS_WN, 32'h0000_0000, 1'b0);
        rchk("key", OFS_KEY, {16'h0000, KEY_RST}, 1'b0);
        rchk("flag", OFS_FLAG, 32'h0000_0000, 1'b0);
        rchk("readback_en", OFS_CO, 32'h0000_0000, 1'b0);
    endtask

    task automatic t_ria();
        rst();
        wchk("locked_wr", OFS_TO, 32'h0000_0300, 1'b0);
        wt(1);
        chk("ria_reset", {31'h0, srr}, 32'h1);
    endtask

    task automatic t_bad();
        cfg(32'h0000_0fff, 32'h0, 32'hfe00_0001);
        rchk("reserved", 14'h001c, 32'h0, 1'b1);
        wchk("ro_write", OFS_CO, 32'h5, 1'b1);
        wchk("bad_code", OFS_SR, 32'h0000_1234, 1'b1);
        mst = 3'h7;
        rchk("no_permit", OFS_CTRL, 32'h0, 1'b1);
        mst = 3'h0;
        rchk("permit", OFS_CTRL, 32'hfe00_0001, 1'b0);
        chk("no_reset", {31'h0, srr}, 32'h0);
    endtask

    task automatic t_fixed();
        cfg(32'h0000_0010, 32'h0, 32'hff00_0001);
        wt(192);
        chk("min_period", {31'h0, srr}, 32'h0);
        svc(SVC_CODE_1, SVC_CODE_2);
        chk("svc_ok", {31'h0, err_v}, 32'h0);
        wt(192);
        chk("reloaded", {31'h0, srr}, 32'h0);
        wait_sig(1'b0, 96);
        chk("timeout_rst", {31'h0, srr}, 32'h1);
    endtask

    task automatic t_itr();
        cfg(32'h0000_0010, 32'h0, 32'hff00_0041);
        wait_sig(1'b1, 288);
        wt(1);
        chk("first_irq", {31'h0, irq}, 32'h1);
        chk("first_norst", {31'h0, srr}, 32'h0);
        rchk("flag_set", OFS_FLAG, 32'h1, 1'b0);
        wchk("flag_w0", OFS_FLAG, 32'h0, 1'b0);
        rchk("flag_kept", OFS_FLAG, 32'h1, 1'b0);
        wchk("flag_w1", OFS_FLAG, 32'h1, 1'b0);
        rchk("flag_clr", OFS_FLAG, 32'h0, 1'b0);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        wait_sig(1'b0, 288);
        chk("second_rst", {31'h0, srr}, 32'h1);
    endtask

    task automatic t_key();
        logic [15:0] k;
        cfg(32'h0000_0010, 32'h0, 32'hff00_0201);
        k = 16'h0100;
        wchk("key_init", OFS_KEY, {16'h0000, k}, 1'b0);
        wchk("fixed_in_key", OFS_SR, {16'h0000, SVC_CODE_1}, 1'b1);
        repeat (2) begin
            k = nk(k);
            wchk("key_ok", OFS_SR, {16'h0000, k}, 1'b0);
            rchk("key_kept", OFS_KEY, {16'h0000, k}, 1'b0);
        end
        bus(1'b1, OFS_CTRL, 32'hff00_0200);
        bus(1'b0, OFS_CO, 32'h0);
        chk("readback_dis", {31'h0, rd_v <= 32'h100 && rd_v > 32'hd0}, 32'h1);
    endtask

    task automatic t_win();
        cfg(32'h0000_0200, 32'h0000_0100, 32'hff00_0081);
        wchk("closed", OFS_SR, {16'h0000, SVC_CODE_1}, 1'b1);
        wt(320);
        wchk("open1", OFS_SR, {16'h0000, SVC_CODE_1}, 1'b0);
        wchk("open2", OFS_SR, {16'h0000, SVC_CODE_2}, 1'b0);
        wt(320);
        chk("win_reload", {31'h0, srr}, 32'h0);
    endtask

    task automatic t_halt();
        cfg(32'h0000_0010, 32'h0, 32'hff00_0007);
        stop <= 1'b1;
        wt(384);
        stop <= 1'b0;
        dbg  <= 1'b1;
        wt(384);
        chk("halted", {31'h0, srr}, 32'h0);
        dbg <= 1'b0;
        wait_sig(1'b0, 288);
        chk("resumed", {31'h0, srr}, 32'h1);
    endtask

    task automatic t_hlk();
        cfg(32'h0000_0300, 32'h0, 32'hff00_0001);
        wchk("hlk_set", OFS_CTRL, 32'hff00_0021, 1'b0);
        wchk("to_locked", OFS_TO, 32'h0000_0400, 1'b1);
        rchk("to_keep", OFS_TO, 32'h0000_0300, 1'b0);
        svc(UNLOCK_CODE_1, UNLOCK_CODE_2);
        rchk("hlk_stays", OFS_CTRL, 32'hff00_0021, 1'b0);
    endtask

    initial begin
        i_ref_clk = 1'b0;
        i_rst_n   = 1'b0;
        m_q       = '0;
        stop      = 1'b0;
        dbg       = 1'b0;
        mst       = 3'h0;
        cyc       = 0;
        n_errors  = 0;
        n_tests   = 0;
        t_reset();
        t_ria();
        t_bad();
        t_fixed();
        t_itr();
        t_key();
        t_win();
        t_halt();
        t_hlk();
        results();
    end
endmodule
`default_nettype wire
